// >>> src/dbmpc_top.sv
`timescale 1ns/1ps
`include "dbmpc_map.svh"
// Contract
// - Forward/reverse inputs drive matching output polarity when below trip.
// - Reverse over trip chops the first output, second stays low.
// - Forward over trip keeps first output low, chops the second.
// - Both inputs high brake with both outputs low.
// - Both inputs low put both outputs in high impedance.
// - All four bridge inputs low over 1 ms enter low-power standby.
// - Drive enables diagonal pair; comparator trip turns it off.
// - Output short latches an independent per-bridge fault, outputs off.
// - Fault latch clears only at standby exit or supply cycling.
// - Overtemperature disables all outputs until it recovers with hysteresis.
// - Undervoltage keeps all drivers off.
// - Off-time rectifies synchronously until zero current is seen.
// - Trip gives fast decay half the off-time, then slow decay.
// - Fast-to-slow change forces drivers off for dead time, no rectification.
module dbmpc_top #(
  parameter int STBY_CYC  = `DBMPC_STBY_CYC,
  parameter int TOFF_CYC  = `DBMPC_TOFF_CYC,
  parameter int COD_CYC   = `DBMPC_COD_CYC,
  parameter int BLANK_CYC = `DBMPC_BLANK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       bridge_a_input_p,
  input  wire logic       bridge_a_input_n,
  input  wire logic       bridge_b_input_p,
  input  wire logic       bridge_b_input_n,
  input  wire logic [1:0] sense_trip,
  input  wire logic [1:0] short_detect,
  input  wire logic [1:0] zero_current,
  input  wire logic       over_temp,
  input  wire logic       load_supply_low,
  output logic            bridge_a_out_p,
  output logic            bridge_a_out_p_oe,
  output logic            bridge_a_out_n,
  output logic            bridge_a_out_n_oe,
  output logic            bridge_b_out_p,
  output logic            bridge_b_out_p_oe,
  output logic            bridge_b_out_n,
  output logic            bridge_b_out_n_oe,
  output logic            standby,
  output logic [1:0]      fault
);
  // ----------------------------------------------------------------------
  // Pin synchronisers; stage one feeds only stage two.
  // ----------------------------------------------------------------------
  localparam int NIN = 12;
  logic [NIN-1:0] raw, s1_reg, s2_reg;
  assign raw = {load_supply_low, over_temp, zero_current, short_detect, sense_trip,
                bridge_b_input_n, bridge_b_input_p, bridge_a_input_n, bridge_a_input_p};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  function automatic dbmpc_pkg::dbmpc_cmd_e decode(input logic p, input logic n);
    decode = dbmpc_pkg::dbmpc_cmd_e'({n, p});
  endfunction : decode

  // ----------------------------------------------------------------------
  // Standby timer: all four bridge inputs low for the timeout enters standby.
  // ----------------------------------------------------------------------
  logic [`DBMPC_CNT_W+4:0] idle_reg, idle_next;
  logic                    stby_reg, stby_next, clr_next, clr_reg;
  logic                    all_low;
  always_comb begin
    all_low   = (s2_reg[3:0] == 4'h0);
    idle_next = idle_reg;
    stby_next = stby_reg;
    if (!all_low) begin
      idle_next = '0;
      stby_next = 1'b0;
    end else if (idle_reg >= ($bits(idle_reg))'(STBY_CYC)) begin
      stby_next = 1'b1;
    end else begin
      idle_next = idle_reg + 1'b1;
    end
    clr_next = stby_reg & ~stby_next;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= '0;
      stby_reg <= 1'b0;
      clr_reg  <= 1'b0;
    end else begin
      idle_reg <= idle_next;
      stby_reg <= stby_next;
      clr_reg  <= clr_next;
    end
  end
  assign standby = stby_reg;

  // ----------------------------------------------------------------------
  // Two bridges. Recovery after standby is the controller's wait.
  // ----------------------------------------------------------------------
  logic [1:0] op, ope, on, one;
  logic       kill;
  assign kill = s2_reg[10] | s2_reg[11];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_br
      dbmpc_bridge #(
        .TOFF_CYC  (TOFF_CYC),
        .COD_CYC   (COD_CYC),
        .BLANK_CYC (BLANK_CYC)
      ) u_br (
        .clk       (clk),
        .rst_n     (rst_n),
        .cmd       (decode(s2_reg[2*g], s2_reg[2*g+1])),
        .trip      (s2_reg[4+g]),
        .short_det (s2_reg[6+g]),
        .zero_cur  (s2_reg[8+g]),
        .fault_clr (clr_reg),
        .out_kill  (kill),
        .out_p     (op[g]),
        .out_p_oe  (ope[g]),
        .out_n     (on[g]),
        .out_n_oe  (one[g]),
        .fault     (fault[g])
      );
    end
  endgenerate
  assign bridge_a_out_p    = op[0];
  assign bridge_a_out_p_oe = ope[0];
  assign bridge_a_out_n    = on[0];
  assign bridge_a_out_n_oe = one[0];
  assign bridge_b_out_p    = op[1];
  assign bridge_b_out_p_oe = ope[1];
  assign bridge_b_out_n    = on[1];
  assign bridge_b_out_n_oe = one[1];

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  coast_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[1:0] == 2'h0 |=> !bridge_a_out_p_oe && !bridge_a_out_n_oe)
    else $error("Coast did not float bridge a.");
  brake_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[1:0] == 2'h3 |=> !bridge_a_out_p && !bridge_a_out_n)
    else $error("Brake did not drive both low.");
  kill_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    kill |=> !bridge_a_out_p_oe && !bridge_b_out_n_oe)
    else $error("Outputs on during temperature or supply shutdown.");
  uv_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[11] |=> !bridge_b_out_p_oe && !bridge_a_out_n_oe)
    else $error("Outputs on during undervoltage.");
  fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault[0] && !clr_reg |=> fault[0])
    else $error("Fault latch dropped without standby exit.");
  fault_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault[1] |-> !bridge_b_out_p_oe && !bridge_b_out_n_oe)
    else $error("Faulted bridge still driving.");
  fwd_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[1:0] == 2'h1 && $stable(s2_reg[1:0]) && !s2_reg[4] && !kill && !fault[0]
    && !s2_reg[6]
    && $past(!s2_reg[4]) && g_br[0].u_br.phase_next == dbmpc_pkg::DBMPC_PH_DRIVE
    |=> bridge_a_out_p && !bridge_a_out_n)
    else $error("Forward drive wrong.");
  stby_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    !standby && all_low && idle_reg == ($bits(idle_reg))'(STBY_CYC) |=> standby)
    else $error("Standby not entered after timeout.");
  stby_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    standby && !all_low |=> !standby ##1 !fault[0] && !fault[1])
    else $error("Standby exit did not clear faults.");

  // ----------------------------------------------------------------------
  // Bridge b mirrors of the coast and brake checks.
  // ----------------------------------------------------------------------
  // Bridge b decodes from its own pin pair; a swapped index would hide here.
  coast_hiz_b_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[3:2] == 2'h0 |=> !bridge_b_out_p_oe && !bridge_b_out_n_oe)
    else $error("Coast did not float bridge b.");
  brake_low_b_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[3:2] == 2'h3 |=> !bridge_b_out_p && !bridge_b_out_n)
    else $error("Brake did not drive bridge b low.");

  // ----------------------------------------------------------------------
  // Fault latch checks for both bridges.
  // ----------------------------------------------------------------------
  // Set must win over the standby clear, so a short always latches.
  short_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[6] |=> fault[0])
    else $error("Short on bridge a not latched.");
  short_latch_b_a: assert property (@(posedge clk) disable iff (!rst_n)
    s2_reg[7] |=> fault[1])
    else $error("Short on bridge b not latched.");
  fault_hold_b_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault[1] && !clr_reg |=> fault[1])
    else $error("Fault latch b dropped without standby exit.");
  fault_a_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault[0] |-> !bridge_a_out_p_oe && !bridge_a_out_n_oe)
    else $error("Faulted bridge a still driving.");

  // ----------------------------------------------------------------------
  // Standby checks.
  // ----------------------------------------------------------------------
  // Standby is only reached from coast, so every driver must be floating.
  stby_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    standby |-> !bridge_a_out_p_oe && !bridge_a_out_n_oe
    && !bridge_b_out_p_oe && !bridge_b_out_n_oe)
    else $error("Driver enabled in standby.");
  stby_leave_a: assert property (@(posedge clk) disable iff (!rst_n)
    !all_low |=> !standby)
    else $error("Standby held with an input high.");
  cv_stby_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(standby));
  cv_fault_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(fault[0]));
  cv_chop_c: cover property (@(posedge clk) disable iff (!rst_n)
    g_br[0].u_br.phase_reg == dbmpc_pkg::DBMPC_PH_SLOW);
  // Wake from standby and a chop on bridge b are the other main paths.
  cv_wake_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(standby));
  cv_chop_b_c: cover property (@(posedge clk) disable iff (!rst_n)
    g_br[1].u_br.phase_reg == dbmpc_pkg::DBMPC_PH_FAST);
endmodule : dbmpc_top

// >>> src/dbmpc_map.svh
`ifndef DBMPC_MAP_SVH
`define DBMPC_MAP_SVH
// ----------------------------------------------------------------------
// Timing figures and derived cycle counts.
// ----------------------------------------------------------------------
`define DBMPC_CLK_MHZ        40
`define DBMPC_TOFF_NS        25000
`define DBMPC_COD_NS         50
`define DBMPC_BLANK_NS       3000
`define DBMPC_STBY_NS        1000000
// Least times round up to whole cycles.
`define DBMPC_TOFF_CYC       ((`DBMPC_TOFF_NS * `DBMPC_CLK_MHZ + 999) / 1000)
`define DBMPC_COD_CYC        ((`DBMPC_COD_NS * `DBMPC_CLK_MHZ + 999) / 1000)
`define DBMPC_BLANK_CYC      ((`DBMPC_BLANK_NS * `DBMPC_CLK_MHZ + 999) / 1000)
`define DBMPC_STBY_CYC       ((`DBMPC_STBY_NS * `DBMPC_CLK_MHZ + 999) / 1000)
`define DBMPC_CNT_W          16
`endif

// >>> src/dbmpc_pkg.sv
package dbmpc_pkg;
  // ----------------------------------------------------------------------
  // Bridge command decoded from the two inputs.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DBMPC_CMD_COAST,
    DBMPC_CMD_FWD,
    DBMPC_CMD_REV,
    DBMPC_CMD_BRAKE
  } dbmpc_cmd_e;
  // Chopper phases of one bridge.
  typedef enum logic [2:0] {
    DBMPC_PH_IDLE,
    DBMPC_PH_DRIVE,
    DBMPC_PH_FAST,
    DBMPC_PH_DEAD,
    DBMPC_PH_SLOW
  } dbmpc_phase_e;
endpackage : dbmpc_pkg

// >>> src/dbmpc_bridge.sv
`timescale 1ns/1ps
`include "dbmpc_map.svh"
module dbmpc_bridge #(
  parameter int TOFF_CYC  = `DBMPC_TOFF_CYC,
  parameter int COD_CYC   = `DBMPC_COD_CYC,
  parameter int BLANK_CYC = `DBMPC_BLANK_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire dbmpc_pkg::dbmpc_cmd_e cmd,
  input  wire logic               trip,
  input  wire logic               short_det,
  input  wire logic               zero_cur,
  input  wire logic               fault_clr,
  input  wire logic               out_kill,
  output logic                    out_p,
  output logic                    out_p_oe,
  output logic                    out_n,
  output logic                    out_n_oe,
  output logic                    fault
);
  dbmpc_pkg::dbmpc_phase_e phase_reg, phase_next;
  logic [`DBMPC_CNT_W-1:0] cnt_reg, cnt_next;
  logic                    fault_reg, fault_next;
  logic                    rect_reg, rect_next;
  logic                    out_p_next, out_n_next, oe_p_next, oe_n_next;
  logic                    fwd;

  // ----------------------------------------------------------------------
  // Chopper: drive, half off-time fast decay, dead time, slow decay.
  // ----------------------------------------------------------------------
  always_comb begin
    fwd        = (cmd == dbmpc_pkg::DBMPC_CMD_FWD);
    phase_next = phase_reg;
    cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    rect_next  = rect_reg;
    // Latched short fault; only standby exit or supply reset clears it.
    fault_next = (fault_reg | short_det) & ~fault_clr;
    // A short that is still present at the clear keeps the latch set.
    if (short_det) begin
      fault_next = 1'b1;
    end
    case (phase_reg)
      dbmpc_pkg::DBMPC_PH_IDLE: begin
        if (fwd || cmd == dbmpc_pkg::DBMPC_CMD_REV) begin
          phase_next = dbmpc_pkg::DBMPC_PH_DRIVE;
          cnt_next   = `DBMPC_CNT_W'(BLANK_CYC);
        end
      end
      dbmpc_pkg::DBMPC_PH_DRIVE: begin
        // Comparator ignored while blanking runs out; ringing would trip it.
        if (!(fwd || cmd == dbmpc_pkg::DBMPC_CMD_REV)) begin
          phase_next = dbmpc_pkg::DBMPC_PH_IDLE;
        end else if (trip && cnt_reg == '0) begin
          phase_next = dbmpc_pkg::DBMPC_PH_FAST;
          // Loads are one short because the terminal count of zero is a cycle too.
          cnt_next   = `DBMPC_CNT_W'(TOFF_CYC / 2 - 1);
          rect_next  = 1'b1;
        end
      end
      dbmpc_pkg::DBMPC_PH_FAST: begin
        if (zero_cur) rect_next = 1'b0;
        if (cnt_reg == '0) begin
          phase_next = dbmpc_pkg::DBMPC_PH_DEAD;
          cnt_next   = `DBMPC_CNT_W'(COD_CYC - 1);
        end
      end
      dbmpc_pkg::DBMPC_PH_DEAD: begin
        if (cnt_reg == '0) begin
          phase_next = dbmpc_pkg::DBMPC_PH_SLOW;
          cnt_next   = `DBMPC_CNT_W'(TOFF_CYC - TOFF_CYC / 2 - COD_CYC - 1);
        end
      end
      dbmpc_pkg::DBMPC_PH_SLOW: begin
        if (zero_cur) rect_next = 1'b0;
        if (cnt_reg == '0) begin
          phase_next = dbmpc_pkg::DBMPC_PH_IDLE;
          rect_next  = 1'b0;
        end
      end
      default: phase_next = dbmpc_pkg::DBMPC_PH_IDLE;
    endcase
    if (cmd == dbmpc_pkg::DBMPC_CMD_COAST || cmd == dbmpc_pkg::DBMPC_CMD_BRAKE) begin
      phase_next = dbmpc_pkg::DBMPC_PH_IDLE;
      rect_next  = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Output levels per command and phase.
  // ----------------------------------------------------------------------
  always_comb begin
    out_p_next = 1'b0;
    out_n_next = 1'b0;
    oe_p_next  = 1'b1;
    oe_n_next  = 1'b1;
    case (cmd)
      dbmpc_pkg::DBMPC_CMD_COAST: begin
        oe_p_next = 1'b0;
        oe_n_next = 1'b0;
      end
      dbmpc_pkg::DBMPC_CMD_BRAKE: ; // Both low.
      default: begin
        case (phase_next)
          dbmpc_pkg::DBMPC_PH_FAST: begin
            // Fast decay: opposite diagonal; the low side is enabled only while rectifying.
            out_p_next = ~fwd;
            out_n_next = fwd;
            oe_p_next  = rect_next | ~fwd;
            oe_n_next  = rect_next | fwd;
          end
          dbmpc_pkg::DBMPC_PH_DEAD: begin
            oe_p_next = 1'b0;
            oe_n_next = 1'b0;
          end
          dbmpc_pkg::DBMPC_PH_SLOW: begin
            // Slow decay: both low; the chopping terminal stays low.
            oe_p_next = rect_next | ~fwd;
            oe_n_next = rect_next | fwd;
          end
          default: begin
            out_p_next = fwd;
            out_n_next = ~fwd;
          end
        endcase
      end
    endcase
    if (fault_next || out_kill) begin
      oe_p_next  = 1'b0;
      oe_n_next  = 1'b0;
      out_p_next = 1'b0;
      out_n_next = 1'b0;
    end
  end

  // Registers for phase, timer, fault and outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= dbmpc_pkg::DBMPC_PH_IDLE;
      cnt_reg   <= '0;
      fault_reg <= 1'b0;
      rect_reg  <= 1'b0;
      out_p     <= 1'b0;
      out_n     <= 1'b0;
      out_p_oe  <= 1'b0;
      out_n_oe  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      fault_reg <= fault_next;
      rect_reg  <= rect_next;
      out_p     <= out_p_next;
      out_n     <= out_n_next;
      out_p_oe  <= oe_p_next;
      out_n_oe  <= oe_n_next;
    end
  end
  assign fault = fault_reg;

  dead_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase_reg == dbmpc_pkg::DBMPC_PH_DEAD |-> !out_p_oe && !out_n_oe)
    else $error("Driver on during dead time.");
endmodule : dbmpc_bridge

// >>> verif/dbmpc_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Host controller model driving the four command pins.
// ----------------------------------------------------------------------
module dbmpc_host #(
  parameter int WAKE_CYC = 1200
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       standby,
  input  wire logic [3:0] cmd,
  output logic      [3:0] pins,
  output logic            ready
);
  int unsigned wait_cnt;
  // Pins move on the falling edge only, so the device never samples them mid-change.
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins     <= 4'h0;
      wait_cnt <= 0;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else begin
      pins <= cmd;
      // A wake from standby holds off any further command until the pump recovers.
      if (standby && cmd != 4'h0) wait_cnt <= WAKE_CYC;
    end
  end
  // Ready only once the pins show the request and no recovery wait is pending.
  assign ready = (wait_cnt == 0) && (pins == cmd);
endmodule : dbmpc_host

// >>> verif/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  // ----------------------------------------------------------------------
  // Stimulus and observed nets.
  // ----------------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [1:0] sense_trip = 2'h0;
  logic [1:0] short_detect = 2'h0;
  logic [1:0] zero_current = 2'h0;
  logic       over_temp = 1'b0;
  logic       load_supply_low = 1'b0;
  wire  [3:0] pins;
  wire        ready;
  wire  [3:0] ov [2];
  wire        standby;
  wire  [1:0] fault;
  int         n_fail = 0;
  int         comparisons = 0;
  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;
  // Short counts keep the standby and off-time waits within a brief run.
  dbmpc_top #(.STBY_CYC(200), .TOFF_CYC(40), .COD_CYC(2), .BLANK_CYC(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .bridge_a_input_p(pins[3]), .bridge_a_input_n(pins[2]),
    .bridge_b_input_p(pins[1]), .bridge_b_input_n(pins[0]), .sense_trip(sense_trip),
    .short_detect(short_detect), .zero_current(zero_current), .over_temp(over_temp),
    .load_supply_low(load_supply_low), .bridge_a_out_p(ov[0][3]),
    .bridge_a_out_p_oe(ov[0][2]), .bridge_a_out_n(ov[0][1]), .bridge_a_out_n_oe(ov[0][0]),
    .bridge_b_out_p(ov[1][3]), .bridge_b_out_p_oe(ov[1][2]), .bridge_b_out_n(ov[1][1]),
    .bridge_b_out_n_oe(ov[1][0]), .standby(standby), .fault(fault));
  dbmpc_host u_host (.clk(clk), .rst_n(rst_n), .standby(standby), .cmd(cmd), .pins(pins),
    .ready(ready));
  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Request a pin pattern, then allow the sync and register latency to pass.
  task automatic drive(input logic [3:0] c);
    int i;
    cmd <= c;
    @(negedge clk);
    for (i = 0; i < 2000 && ready !== 1'b1; i++) @(negedge clk);
    if (i == 2000) begin
      n_fail++;
      close_out();
    end
    repeat (4) @(negedge clk);
  endtask : drive
  // Coast leaves the levels undefined, so only the enables are compared then.
  task automatic look(input int b, input logic [1:0] c);
    logic [3:0] m;
    logic [3:0] e;
    m = (c == 2'b00) ? 4'h5 : 4'hF;
    e = (c == 2'b01) ? 4'h7 : (c == 2'b10) ? 4'hD : (c == 2'b11) ? 4'h5 : 4'h0;
    `CHK(ov[b] & m, e & m)
  endtask : look
  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic table_walk();
    for (int k = 0; k < 4; k++) begin
      drive({2'(k), 2'(k + 1)});
      look(0, 2'(k));
      look(1, 2'(k + 1));
    end
  endtask : table_walk
  // One chop cycle: a trip in blanking, then a real trip whose off-time is profiled.
  task automatic chop(input int b, input logic rev, input logic zc);
    logic [1:0] c;
    logic [3:0] v;
    logic [1:0] hot;
    logic [1:0] oth;
    int fast, dead, ooff, ohi, clo;
    c = rev ? 2'b01 : 2'b10;
    fast = 0; dead = 0; ooff = 0; ohi = 0; clo = 0;
    zero_current[b] <= zc;
    drive(b == 0 ? {c, 2'b00} : {2'b00, c});
    sense_trip[b] <= 1'b1;
    repeat (3) @(negedge clk);
    sense_trip[b] <= 1'b0;
    look(b, c);
    repeat (10) @(negedge clk);
    sense_trip[b] <= 1'b1;
    @(negedge clk);
    sense_trip[b] <= 1'b0;
    // Let the trip cross the synchroniser so only the off-time is profiled.
    repeat (2) @(negedge clk);
    for (int i = 0; i < 38; i++) begin
      v = ov[b];
      hot = rev ? v[3:2] : v[1:0];
      oth = rev ? v[1:0] : v[3:2];
      fast += (hot == 2'b11);
      clo += (hot == 2'b01);
      dead += (v[2] == 1'b0 && v[0] == 1'b0);
      ooff += (oth[0] == 1'b0);
      ohi += (oth == 2'b11);
      @(negedge clk);
    end
    `CHK(ohi, 0)
    `CHK(clo > 0, 1'b1)
    `CHK(fast, 20)
    if (zc) begin
      `CHK(ooff > 2, 1'b1)
    end else begin
      `CHK(dead, 2)
      `CHK(ooff, 2)
    end
    repeat (10) @(negedge clk);
    look(b, c);
    zero_current[b] <= 1'b0;
  endtask : chop
  task automatic protect();
    drive(4'b1001);
    for (int k = 0; k < 2; k++) begin
      over_temp <= (k == 0);
      load_supply_low <= (k == 1);
      repeat (5) @(negedge clk);
      `CHK({ov[0], ov[1]} & 8'h55, 8'h00)
      over_temp <= 1'b0;
      load_supply_low <= 1'b0;
      repeat (5) @(negedge clk);
      `CHK({ov[0], ov[1]}, 8'hD7)
    end
  endtask : protect
  // The latched fault must survive command changes and clear only on standby exit.
  task automatic fault_standby();
    drive(4'b1001);
    short_detect[0] <= 1'b1;
    @(negedge clk);
    short_detect[0] <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(fault, 2'b01)
    `CHK(ov[0] & 4'h5, 4'h0)
    `CHK(ov[1], 4'h7)
    drive(4'b0001);
    drive(4'b1001);
    `CHK(fault, 2'b01)
    `CHK(ov[0] & 4'h5, 4'h0)
    drive(4'b0000);
    repeat (185) @(negedge clk);
    `CHK(standby, 1'b0)
    for (int i = 0; i < 40 && standby !== 1'b1; i++) @(negedge clk);
    `CHK(standby, 1'b1)
    drive(4'b1000);
    `CHK(standby, 1'b0)
    `CHK(fault, 2'b00)
    `CHK(ov[0], 4'hD)
  endtask : fault_standby
  // Main sequence.
  initial begin
    repeat (16) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({ov[0], ov[1], standby, fault}, 11'h000)
    table_walk();
    chop(0, 1'b0, 1'b0);
    chop(1, 1'b1, 1'b0);
    chop(0, 1'b0, 1'b1);
    protect();
    fault_standby();
    close_out();
  end
endmodule : tb
